// file: shared/tapc_defines.vh
// Register map, reset values and timing counts of the system control block
`ifndef TAPC_DEFINES_VH
`define TAPC_DEFINES_VH
// ****************************************
// Register offsets
// ****************************************
`define TAPC_OFS_POWER_CONTROL 8'h87
`define TAPC_OFS_SYSTEM_CLOCK_SOURCE 8'h8F
`define TAPC_OFS_WAKE_MASK 8'h9F
`define TAPC_OFS_POWER_MODE_DIV 8'hC4
`define TAPC_OFS_ACTIVITY_STATUS 8'hC5
`define TAPC_OFS_SINGLE_UNLOCK 8'hC7
`define TAPC_OFS_WINDOW_UNLOCK 8'hC9
`define TAPC_OFS_WATCHDOG_CFG 8'hD8
`define TAPC_OFS_MEMORY_CFG 8'hC6
`define TAPC_OFS_ACCESS_CFG 8'h9D
`define TAPC_XFR_TRIM_BASE 16'hA000
// ****************************************
// Unlock key values
// ****************************************
`define TAPC_KEY_FIRST 8'hAA
`define TAPC_KEY_SECOND 8'h55
`define TAPC_KEY_CLOSE 8'h00
// ****************************************
// Field positions
// ****************************************
`define TAPC_PC_SMOD0 7
`define TAPC_PC_SLEEP 2
`define TAPC_PC_STOP 1
`define TAPC_PC_IDLE 0
`define TAPC_PM_DIV_HI 7
`define TAPC_PM_DIV_LO 6
`define TAPC_PM_SWB 5
`define TAPC_ST_HIGH_PRIO 6
`define TAPC_ST_LOW_PRIO 5
`define TAPC_ST_TX_ACTIVE 1
`define TAPC_ST_RX_ACTIVE 0
`define TAPC_CK_DELAY_MSB 7
`define TAPC_CK_DELAY_LSB 5
`define TAPC_CK_SRC_MSB 1
`define TAPC_CK_SRC_LSB 0
// ****************************************
// Reset values
// ****************************************
`define TAPC_RST_POWER_CONTROL 8'h00
`define TAPC_RST_SYSTEM_CLOCK_SOURCE 8'hC0
`define TAPC_RST_WAKE_MASK 8'hFF
`define TAPC_RST_POWER_MODE_DIV 8'h40
// ****************************************
// Timing counts
// ****************************************
`define TAPC_WINDOW_CYCLES 9'h100
`define TAPC_PMM_DIVIDE 9'h101
`define TAPC_SETTLE_TICKS 7'h40
`define TAPC_DELAY_BASE 14'h0080
`endif

// file: hdl/tapc_sync2.v
// Two flip-flop synchroniser for a group of asynchronous levels
module tapc_sync2 #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // tapc_sync2

// file: hdl/tapc_core.v
// Timed-access protection, power modes and clock selection of the MCU core
`include "tapc_defines.vh"
module tapc_core (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Special-function register port
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  // Extended register write gate
  input wire [15:0] xfr_addr,
  input wire xfr_wr,
  output wire xfr_wr_allow,
  // Write enables of protected registers held elsewhere
  output wire watchdog_cfg_wr,
  output wire memory_cfg_wr,
  output wire access_config_wr,
  // Wake and switchback sources
  input wire [7:0] wake_irq,
  input wire irq_wake_req,
  input wire ext_irq_taken,
  input wire uart0_rx_start,
  input wire uart0_tx_load,
  input wire internal_fast_oscillator_tick,
  // Activity sources
  input wire high_prio_active,
  input wire low_prio_active,
  input wire uart0_tx_active,
  input wire uart0_rx_active,
  // Clock and power controls
  output reg cpu_clk_en,
  output reg periph_clk_en,
  output reg bandgap_en,
  output reg regulator_en,
  output reg [1:0] clock_source_field,
  output reg uart0_double_baud
);
  // ****************************************
  // State codes
  // ****************************************
  localparam ST_RUN = 6'b000001;
  localparam ST_IDLE = 6'b000010;
  localparam ST_STOP = 6'b000100;
  localparam ST_SLEEP = 6'b001000;
  localparam ST_SETTLE = 6'b010000;
  localparam ST_DELAY = 6'b100000;

  // ****************************************
  // Declarations
  // ****************************************
  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg single_armed_r;
  reg single_unlock_state_r;
  reg window_armed_r;
  reg [8:0] window_cnt_r;
  reg [7:0] power_control_r;
  reg [7:0] power_mode_divider_r;
  reg [7:0] system_clock_source_select_r;
  reg [7:0] wake_source_mask_r;
  reg [7:0] activity_status_r;
  reg [7:0] wake_prev_r;
  reg [8:0] pmm_cnt_r;
  reg [13:0] wait_cnt_r;
  reg [13:0] wait_cnt_nxt;
  reg [13:0] delay_ticks;
  reg wake_done;
  wire [7:0] wake_sync;
  wire [7:0] wake_edge;
  wire stop_wake;
  wire window_open_state;
  wire wr_single;
  wire wr_window;
  wire acc_single;
  wire single_prot_hit;
  wire xfr_prot_hit;
  wire switchback;
  wire reduced_speed_mode;
  wire [2:0] wake_delay_field;

  // ****************************************
  // Wake line synchronisation
  // ****************************************
  tapc_sync2 #(
    .WIDTH(8)
  ) u_wake_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(wake_irq),
    .sync_out(wake_sync)
  );

  assign wake_edge = wake_sync & ~wake_prev_r & wake_source_mask_r;
  assign stop_wake = |wake_edge;

  // ****************************************
  // Access decode
  // ****************************************
  assign wr_single = sfr_wr && (sfr_addr == `TAPC_OFS_SINGLE_UNLOCK);
  assign wr_window = sfr_wr && (sfr_addr == `TAPC_OFS_WINDOW_UNLOCK);
  assign acc_single = (sfr_wr || sfr_rd) && (sfr_addr == `TAPC_OFS_SINGLE_UNLOCK);
  assign single_prot_hit = sfr_wr && ((sfr_addr == `TAPC_OFS_WATCHDOG_CFG) ||
    (sfr_addr == `TAPC_OFS_MEMORY_CFG) || (sfr_addr == `TAPC_OFS_ACCESS_CFG));
  assign window_open_state = (window_cnt_r != 9'h000);
  assign xfr_prot_hit = (xfr_addr == `TAPC_XFR_TRIM_BASE) ||
    (xfr_addr == 16'hA001) || (xfr_addr == 16'hA002) || (xfr_addr == 16'hA007) ||
    (xfr_addr == 16'hA010) || (xfr_addr == 16'hA011) || (xfr_addr == 16'hA013) ||
    (xfr_addr == 16'hA014) || (xfr_addr == 16'hA025) || (xfr_addr == 16'hA026) ||
    (xfr_addr == 16'hA0E1) || (xfr_addr == 16'hA0EF);
  assign xfr_wr_allow = xfr_wr && (!xfr_prot_hit || window_open_state);

  // Protected single-unlock writes pass only while permitted
  assign watchdog_cfg_wr = sfr_wr && (sfr_addr == `TAPC_OFS_WATCHDOG_CFG) &&
    single_unlock_state_r;
  assign memory_cfg_wr = sfr_wr && (sfr_addr == `TAPC_OFS_MEMORY_CFG) &&
    single_unlock_state_r;
  assign access_config_wr = sfr_wr && (sfr_addr == `TAPC_OFS_ACCESS_CFG) &&
    single_unlock_state_r;

  // ****************************************
  // Single-write unlock
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      single_armed_r <= 1'b0;
      single_unlock_state_r <= 1'b0;
    end
    else if (acc_single)
    begin
      single_armed_r <= wr_single && (sfr_wdata == `TAPC_KEY_FIRST);
      single_unlock_state_r <= wr_single && single_armed_r &&
        (sfr_wdata == `TAPC_KEY_SECOND);
    end
    else if (single_prot_hit)
    begin
      single_unlock_state_r <= 1'b0;
    end
  end

  // ****************************************
  // Timed window unlock
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      window_armed_r <= 1'b0;
      window_cnt_r <= 9'h000;
    end
    else if (wr_window)
    begin
      window_armed_r <= (sfr_wdata == `TAPC_KEY_FIRST);
      if (sfr_wdata == `TAPC_KEY_CLOSE)
        window_cnt_r <= 9'h000;
      else if (window_armed_r && (sfr_wdata == `TAPC_KEY_SECOND))
        window_cnt_r <= `TAPC_WINDOW_CYCLES;
      else if (window_open_state)
        window_cnt_r <= window_cnt_r - 9'h001;
    end
    else if (window_open_state)
    begin
      window_cnt_r <= window_cnt_r - 9'h001;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  assign reduced_speed_mode = power_mode_divider_r[`TAPC_PM_DIV_HI] &&
    power_mode_divider_r[`TAPC_PM_DIV_LO];
  assign switchback = power_mode_divider_r[`TAPC_PM_SWB] && reduced_speed_mode &&
    (ext_irq_taken || uart0_rx_start || uart0_tx_load);
  assign wake_delay_field = system_clock_source_select_r[`TAPC_CK_DELAY_MSB:`TAPC_CK_DELAY_LSB];

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_control_r <= `TAPC_RST_POWER_CONTROL;
      power_mode_divider_r <= `TAPC_RST_POWER_MODE_DIV;
      system_clock_source_select_r <= `TAPC_RST_SYSTEM_CLOCK_SOURCE;
      wake_source_mask_r <= `TAPC_RST_WAKE_MASK;
      activity_status_r <= 8'h00;
      wake_prev_r <= 8'h00;
    end
    else
    begin
      wake_prev_r <= wake_sync;
      activity_status_r <= 8'h00;
      activity_status_r[`TAPC_ST_HIGH_PRIO] <= high_prio_active;
      activity_status_r[`TAPC_ST_LOW_PRIO] <= low_prio_active;
      activity_status_r[`TAPC_ST_TX_ACTIVE] <= uart0_tx_active;
      activity_status_r[`TAPC_ST_RX_ACTIVE] <= uart0_rx_active;
      if (sfr_wr && (sfr_addr == `TAPC_OFS_POWER_CONTROL) && (state_r == ST_RUN))
        power_control_r <= {sfr_wdata[7], 4'h0, sfr_wdata[2:0]};
      else if (wake_done)
        power_control_r <= power_control_r & 8'h80;
      if (switchback)
        power_mode_divider_r <= {2'b01, power_mode_divider_r[5], 5'h00};
      else if (sfr_wr && (sfr_addr == `TAPC_OFS_POWER_MODE_DIV))
        power_mode_divider_r <= {sfr_wdata[7:5], 5'h00};
      if (sfr_wr && (sfr_addr == `TAPC_OFS_SYSTEM_CLOCK_SOURCE) && window_open_state)
        system_clock_source_select_r <= {sfr_wdata[7:5], 3'h0, sfr_wdata[1:0]};
      if (sfr_wr && (sfr_addr == `TAPC_OFS_WAKE_MASK) && window_open_state)
        wake_source_mask_r <= sfr_wdata;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `TAPC_OFS_POWER_CONTROL: sfr_rdata <= power_control_r;
        `TAPC_OFS_SYSTEM_CLOCK_SOURCE: sfr_rdata <= system_clock_source_select_r;
        `TAPC_OFS_WAKE_MASK: sfr_rdata <= wake_source_mask_r;
        `TAPC_OFS_POWER_MODE_DIV: sfr_rdata <= power_mode_divider_r;
        `TAPC_OFS_ACTIVITY_STATUS: sfr_rdata <= activity_status_r;
        `TAPC_OFS_SINGLE_UNLOCK: sfr_rdata <= {7'h00, single_unlock_state_r};
        `TAPC_OFS_WINDOW_UNLOCK: sfr_rdata <= {7'h00, window_open_state};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Wake delay decode
  // ****************************************
  always @*
  begin
    delay_ticks = 14'h0000;
    if (wake_delay_field != 3'b000)
      delay_ticks = `TAPC_DELAY_BASE << (wake_delay_field - 3'b001);
  end

  // ****************************************
  // Power mode sequencer
  // ****************************************
  // Permissions are untouched by mode changes: the window keeps counting down and a single grant lasts until used or the unlock register is next accessed
  always @*
  begin
    state_nxt = state_r;
    wait_cnt_nxt = wait_cnt_r;
    wake_done = 1'b0;
    case (state_r)
      ST_RUN:
      begin
        if (power_control_r[`TAPC_PC_STOP] && power_control_r[`TAPC_PC_SLEEP])
          state_nxt = ST_SLEEP;
        else if (power_control_r[`TAPC_PC_STOP])
          state_nxt = ST_STOP;
        else if (power_control_r[`TAPC_PC_IDLE])
          state_nxt = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (irq_wake_req || stop_wake)
        begin
          state_nxt = ST_RUN;
          wake_done = 1'b1;
        end
      end
      ST_STOP:
      begin
        if (stop_wake)
        begin
          state_nxt = ST_RUN;
          wake_done = 1'b1;
        end
      end
      ST_SLEEP:
      begin
        if (stop_wake)
        begin
          state_nxt = ST_SETTLE;
          wait_cnt_nxt = {7'h00, `TAPC_SETTLE_TICKS};
        end
      end
      ST_SETTLE:
      begin
        if (internal_fast_oscillator_tick)
          wait_cnt_nxt = wait_cnt_r - 14'h0001;
        if (internal_fast_oscillator_tick && (wait_cnt_r == 14'h0001))
        begin
          state_nxt = ST_DELAY;
          wait_cnt_nxt = delay_ticks;
        end
      end
      ST_DELAY:
      begin
        if (wait_cnt_r == 14'h0000)
        begin
          state_nxt = ST_RUN;
          wake_done = 1'b1;
        end
        else if (internal_fast_oscillator_tick)
          wait_cnt_nxt = wait_cnt_r - 14'h0001;
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_RUN;
      wait_cnt_r <= 14'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // ****************************************
  // Reduced-speed divider
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pmm_cnt_r <= 9'h000;
    else if (!reduced_speed_mode || (pmm_cnt_r == `TAPC_PMM_DIVIDE - 9'h001))
      pmm_cnt_r <= 9'h000;
    else
      pmm_cnt_r <= pmm_cnt_r + 9'h001;
  end

  // ****************************************
  // Clock and power outputs
  // ****************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      bandgap_en <= 1'b1;
      regulator_en <= 1'b1;
      clock_source_field <= 2'b00;
      uart0_double_baud <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= (state_nxt == ST_RUN) &&
        (!reduced_speed_mode || (pmm_cnt_r == 9'h000));
      periph_clk_en <= (state_nxt == ST_RUN) || (state_nxt == ST_IDLE);
      bandgap_en <= (state_nxt != ST_SLEEP);
      regulator_en <= (state_nxt != ST_SLEEP) && (state_nxt != ST_SETTLE);
      clock_source_field <= system_clock_source_select_r[`TAPC_CK_SRC_MSB:`TAPC_CK_SRC_LSB];
      uart0_double_baud <= power_control_r[`TAPC_PC_SMOD0];
    end
  end
endmodule // tapc_core

// file: dv/tapc_core_chk.sv
// Port assertions of the system control block
module tapc_core_chk (
  // Clock and reset
  input logic core_clk,
  input logic rst_n,
  // Register ports
  input logic [7:0] sfr_addr,
  input logic [7:0] sfr_wdata,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_rdata,
  input logic [15:0] xfr_addr,
  input logic xfr_wr,
  input logic xfr_wr_allow,
  // Gates and clock controls
  input logic watchdog_cfg_wr,
  input logic memory_cfg_wr,
  input logic access_config_wr,
  input logic cpu_clk_en,
  input logic periph_clk_en,
  input logic bandgap_en,
  input logic regulator_en,
  input logic [1:0] clock_source_field
);
  timeunit 1ns;
  timeprecision 1ps;
  wire gate_any = watchdog_cfg_wr | memory_cfg_wr | access_config_wr;
  wire quiet = !sfr_wr && !sfr_rd;
  wire run_wr = sfr_wr && sfr_addr == 8'h87 && cpu_clk_en && periph_clk_en;
  wire src_wr = sfr_wr && sfr_addr == 8'h8F;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_gate_target: assert property (gate_any |-> sfr_wr && {watchdog_cfg_wr, memory_cfg_wr,
    access_config_wr} == {sfr_addr == 8'hD8, sfr_addr == 8'hC6, sfr_addr == 8'h9D})
    else $error("protected enable without its write");
  a_ticket_used: assert property (gate_any |=> !gate_any)
    else $error("single permission reused");
  a_pair_grants: assert property ((sfr_wr && sfr_addr == 8'hC7 && sfr_wdata == 8'hAA) ##1 quiet
    ##1 (sfr_wr && sfr_addr == 8'hC7 && sfr_wdata == 8'h55) ##1 quiet
    ##1 (sfr_wr && sfr_addr == 8'hD8) |-> watchdog_cfg_wr)
    else $error("unlock pair did not grant");
  a_lock_bits: assert property (sfr_rd && sfr_addr inside {8'hC7, 8'hC9} |=>
    sfr_rdata[7:1] == 7'h00)
    else $error("unlock read has upper bits set");
  a_window_gate: assert property (xfr_wr && !(xfr_addr inside {16'hA000, 16'hA001, 16'hA002,
    16'hA007, 16'hA010, 16'hA011, 16'hA013, 16'hA014, 16'hA025, 16'hA026, 16'hA0E1,
    16'hA0EF}) |-> xfr_wr_allow)
    else $error("unprotected extended write refused");
  a_sleep_off: assert property (!bandgap_en |-> !regulator_en && !cpu_clk_en &&
    !periph_clk_en)
    else $error("sleep with a clock or regulator on");
  a_stop_entry: assert property (run_wr && sfr_wdata[2:0] == 3'b010 |->
    ##[1:3] (!cpu_clk_en && !periph_clk_en))
    else $error("stop not entered");
  a_idle_entry: assert property (run_wr && sfr_wdata[2:0] == 3'b001 |->
    ##[1:3] (!cpu_clk_en && periph_clk_en))
    else $error("idle not entered");
  a_src_by_write: assert property ($changed(clock_source_field) |-> $past(src_wr, 2))
    else $error("clock source changed without a write");
endmodule // tapc_core_chk

// file: dv/timed_access_power_clock_ctrl_bench.sv
// Self-checking bench of the system control block
module timed_access_power_clock_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic rst_n = 0;
  logic [7:0] sfr_addr = 0;
  logic [7:0] sfr_wdata = 0;
  logic sfr_wr = 0;
  logic sfr_rd = 0;
  logic [15:0] xfr_addr = 0;
  logic xfr_wr = 0;
  logic [7:0] wake_irq = 0;
  logic irq_wake_req = 0;
  logic [2:0] trig = 0;
  logic [3:0] act = 0;
  logic internal_fast_oscillator_tick = 0;
  logic [1:0] internal_fast_oscillator_div = 0;
  logic [2:0] gates;
  logic [7:0] rd_val;
  wire [7:0] sfr_rdata;
  wire xfr_wr_allow, watchdog_cfg_wr, memory_cfg_wr, access_config_wr;
  wire cpu_clk_en, periph_clk_en, bandgap_en, regulator_en;
  wire [1:0] clock_source_field;
  wire uart0_double_baud;
  int miscompares = 0;
  int checks_done = 0;
  int k;
  int n;
  logic [7:0] ra [8] = '{8'h87, 8'h8F, 8'h9F, 8'hC4, 8'hC5, 8'hC9, 8'hC7, 8'hB0};
  logic [7:0] rv [8] = '{8'h00, 8'hC0, 8'hFF, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wp [3] = '{8'hD8, 8'hC6, 8'h9D};
  logic [7:0] sv [4] = '{8'h01, 8'h02, 8'h20, 8'h40};
  tapc_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .xfr_addr(xfr_addr),
    .xfr_wr(xfr_wr), .xfr_wr_allow(xfr_wr_allow), .watchdog_cfg_wr(watchdog_cfg_wr),
    .memory_cfg_wr(memory_cfg_wr), .access_config_wr(access_config_wr), .wake_irq(wake_irq),
    .irq_wake_req(irq_wake_req), .ext_irq_taken(trig[2]), .uart0_rx_start(trig[0]),
    .uart0_tx_load(trig[1]), .internal_fast_oscillator_tick(internal_fast_oscillator_tick), .high_prio_active(act[3]),
    .low_prio_active(act[2]), .uart0_tx_active(act[1]), .uart0_rx_active(act[0]),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .bandgap_en(bandgap_en),
    .regulator_en(regulator_en), .clock_source_field(clock_source_field),
    .uart0_double_baud(uart0_double_baud)
  );
  always #2 core_clk = ~core_clk;
  // Oscillator tick once every four core cycles
  always @(posedge core_clk)
  begin
    internal_fast_oscillator_div <= internal_fast_oscillator_div + 2'h1;
    internal_fast_oscillator_tick <= (internal_fast_oscillator_div == 2'h0);
  end
  // *****
  // Access tasks and comparisons
  // *****
  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] got);
    checks_done++;
    if (got !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    #1 gates = {watchdog_cfg_wr, memory_cfg_wr, access_config_wr};
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 rd_val = sfr_rdata;
    check_byte(what, e, rd_val);
    @(posedge core_clk);
  endtask
  task automatic xwr(input logic [15:0] a, input logic e);
    xfr_addr <= a;
    xfr_wr <= 1'b1;
    #1 check_byte("xfr_wr_allow", {7'h00, e}, {7'h00, xfr_wr_allow});
    @(posedge core_clk);
    xfr_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pwr_chk(input logic [3:0] e);
    #1 check_byte("clock enables", {4'h0, e},
      {4'h0, cpu_clk_en, periph_clk_en, bandgap_en, regulator_en});
    @(posedge core_clk);
  endtask
  task automatic unlock(input logic [7:0] a);
    wr(a, 8'hAA);
    wr(a, 8'h55);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    report_and_stop;
  end
  // *****
  // Test sequence
  // *****
  initial
  begin
    cyc(5);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (k = 0; k < 8; k++)
      rd_chk("reset value", ra[k], rv[k]);
    $display("reset test done");
    wr(8'hC6, 8'h01);
    check_byte("gates", 8'h00, {5'h00, gates});
    unlock(8'hC7);
    rd_chk("single_unlock_state", 8'hC7, 8'h01);
    rd_chk("single_unlock_state", 8'hC7, 8'h00);
    for (k = 0; k < 3; k++)
    begin
      unlock(8'hC7);
      cyc(50 * k);
      wr(wp[k], 8'h01);
      check_byte("gates", 8'h04 >> k, {5'h00, gates});
      wr(wp[k], 8'h01);
      check_byte("gates", 8'h00, {5'h00, gates});
    end
    $display("single unlock test done");
    wr(8'h8F, 8'h41);
    rd_chk("system_clock_source_select", 8'h8F, 8'hC0);
    xwr(16'hA001, 1'b0);
    unlock(8'hC9);
    rd_chk("window_open_state", 8'hC9, 8'h01);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h8F, k[7:0]);
      rd_chk("system_clock_source_select", 8'h8F, k[7:0]);
      check_byte("clock_source_field", k[7:0], {6'h00, clock_source_field});
    end
    xwr(16'hA0EF, 1'b1);
    wr(8'h9F, 8'h01);
    rd_chk("wake_source_mask", 8'h9F, 8'h01);
    wr(8'hC9, 8'h00);
    rd_chk("window_open_state", 8'hC9, 8'h00);
    wr(8'h8F, 8'h22);
    rd_chk("system_clock_source_select", 8'h8F, 8'h03);
    xwr(16'hA003, 1'b1);
    xwr(16'hA0E1, 1'b0);
    unlock(8'hC9);
    cyc(240);
    rd_chk("window_open_state", 8'hC9, 8'h01);
    cyc(20);
    rd_chk("window_open_state", 8'hC9, 8'h00);
    unlock(8'hC9);
    cyc(200);
    unlock(8'hC9);
    cyc(200);
    rd_chk("window_open_state", 8'hC9, 8'h01);
    wr(8'h8F, 8'h20);
    wr(8'hC9, 8'h00);
    $display("window test done");
    for (k = 0; k < 4; k++)
    begin
      act <= 4'h1 << k;
      cyc(3);
      rd_chk("activity_status", 8'hC5, sv[k]);
    end
    act <= 4'h0;
    $display("status test done");
    wr(8'hC4, 8'hC0);
    n = 0;
    repeat (514)
    begin
      @(posedge core_clk);
      #1 n += cpu_clk_en;
    end
    check_byte("slow clock pulses", 8'h02, n[7:0]);
    @(posedge core_clk);
    trig <= 3'b001;
    @(posedge core_clk);
    trig <= 3'b000;
    rd_chk("power_mode_divider", 8'hC4, 8'hC0);
    for (k = 0; k < 3; k++)
    begin
      wr(8'hC4, 8'hE0);
      trig <= 3'b001 << k;
      @(posedge core_clk);
      trig <= 3'b000;
      rd_chk("power_mode_divider", 8'hC4, 8'h60);
    end
    cyc(4);
    pwr_chk(4'hF);
    $display("divider test done");
    unlock(8'hC9);
    wr(8'h87, 8'h01);
    cyc(3);
    pwr_chk(4'h7);
    irq_wake_req <= 1'b1;
    cyc(4);
    pwr_chk(4'hF);
    irq_wake_req <= 1'b0;
    rd_chk("power_control", 8'h87, 8'h00);
    rd_chk("window_open_state", 8'hC9, 8'h01);
    wr(8'hC9, 8'h00);
    wr(8'h87, 8'h02);
    cyc(3);
    pwr_chk(4'h3);
    wake_irq <= 8'h02;
    cyc(10);
    pwr_chk(4'h3);
    wake_irq <= 8'h03;
    cyc(8);
    pwr_chk(4'hF);
    rd_chk("power_control", 8'h87, 8'h00);
    wake_irq <= 8'h00;
    wr(8'h87, 8'h06);
    cyc(3);
    pwr_chk(4'h0);
    wake_irq <= 8'h01;
    cyc(100);
    pwr_chk(4'h2);
    cyc(236);
    pwr_chk(4'h3);
    cyc(465);
    pwr_chk(4'hF);
    rd_chk("power_control", 8'h87, 8'h00);
    wake_irq <= 8'h00;
    wr(8'h87, 8'h80);
    rd_chk("power_control", 8'h87, 8'h80);
    check_byte("uart0_double_baud", 8'h01, {7'h00, uart0_double_baud});
    $display("power mode test done");
    report_and_stop;
  end
endmodule // timed_access_power_clock_ctrl_bench
bind tapc_core tapc_core_chk u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .xfr_addr(xfr_addr),
  .xfr_wr(xfr_wr), .xfr_wr_allow(xfr_wr_allow), .watchdog_cfg_wr(watchdog_cfg_wr),
  .memory_cfg_wr(memory_cfg_wr), .access_config_wr(access_config_wr),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .bandgap_en(bandgap_en),
  .regulator_en(regulator_en), .clock_source_field(clock_source_field)
);
